// [rtl/frb_pkg.sv]
/*
 * constants, types and carriers shared by the flash read buffer controller.
 * assumes a flash array of 128-bit words behind one 32-bit bus slave port.
 */
package frb_pkg;
    // flash word geometry
    localparam int FW_BITS       = 128;
    localparam int BUS_BITS      = 32;
    localparam int FW_ADDR_W     = 16;       // flash word index, off[19:4]
    localparam int OFS_W         = 20;       // byte offset inside flash
    localparam int PAGE_WORDS_LOG = 5;       // 32 flash words per page
    localparam int PAGE_W        = FW_ADDR_W - PAGE_WORDS_LOG;
    localparam int SMALL_PAGES   = 16;
    localparam int LARGE_PAGES   = 128;
    localparam logic [1:0] LAST_LANE = 2'h3;

    // address map
    localparam logic [31:0] FLASH_BASE = 32'h2000_0000;
    localparam logic [31:0] LARGE_BASE = 32'h2001_0000;
    localparam logic [OFS_W-1:0] LARGE_OFS = 20'h1_0000;
    localparam logic [4:0] SMALL_FIRST = 5'h0b; // small sectors 11..18
    localparam logic [3:0] LARGE_SKEW  = 4'h1;  // large sector n at n+1
    localparam int N_SECT_MAX    = 19;

    // index sector word layout
    localparam int IDX_JTAG_BIT  = 31;
    localparam int IDX_PROG_BIT  = 30;
    localparam logic [FW_ADDR_W-1:0] IDX_WORD = 16'h0000;

    // wait states above this figure defeat zero-wait speculation
    localparam logic [7:0] SPEC_FULL_WST = 8'h03;
    localparam logic [7:0] WST_RESET     = 8'h03;

    // read timing and buffering modes
    typedef enum logic [2:0] {
        MODE_SYNC_NOBUF   = 3'h0,
        MODE_SYNC_SINGLE  = 3'h1,
        MODE_ASYNC_NOBUF  = 3'h2,
        MODE_ASYNC_SINGLE = 3'h3,
        MODE_ASYNC_DUAL1  = 3'h4,
        MODE_ASYNC_DUALA  = 3'h5
    } frb_mode_e;

    typedef enum logic [4:0] {
        ST_INIT  = 5'b00001,
        ST_IDLE  = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_ERR1  = 5'b01000,
        ST_ERR2  = 5'b10000
    } frb_state_e;

    // bus request side
    typedef struct packed {
        logic                hsel;
        logic [31:0]         haddr;
        logic [1:0]          htrans;
        logic                hwrite;
        logic [BUS_BITS-1:0] hwdata;
        logic                hready;
    } frb_ahb_in_s;

    // commands toward the flash array
    typedef struct packed {
        logic                 rd;
        logic                 abort;
        logic                 index;
        logic [FW_ADDR_W-1:0] rd_addr;
        logic                 load;
        logic                 burn;
        logic                 erase;
        logic [FW_ADDR_W-1:0] wr_addr;
        logic [4:0]           sector;
        logic [FW_BITS-1:0]   wdata;
    } frb_arr_cmd_s;
endpackage

// [rtl/frb_wait_timer.sv]
/*
 * down counter timing array reads and the power-on initialization.
 * assumes load is a one-cycle strobe; a load while running restarts it.
 */
`timescale 1ns/1ps
module frb_wait_timer #(
    parameter int W = 16
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         load,
    input  wire logic [W-1:0] value,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] count;

    // count down to zero, then stop
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= '0;
            busy  <= 1'b0;
        end else if (load) begin
            count <= value;
            busy  <= 1'b1;
        end else if (busy) begin
            if (count == '0) begin
                busy <= 1'b0;
            end else begin
                count <= count - 1'b1;
            end
        end
    end

    // done in the last counted cycle
    assign done = busy && (count == '0);
endmodule // frb_wait_timer

// [rtl/frb_ctrl.sv]
/*
 * flash read buffer controller: bus slave, buffers, program, erase.
 * assumes arr_rdata valid when the wait timer ends and arr_done
 * pulses at the end of a burn or erase; config comes as plain ports.
 */
// Function
// - fetch 128-bit words, two buffer lines
// - stall flash transfers until initialization ends
// - read index sector; block secured sector reads
// - jtag protection disables jtag and debug
// - synchronous timing: no abort, no speculation
// - asynchronous timing: abort allows speculation, dual
// - buffer line serves any of four words
// - no buffering: every read hits array
// - same-word read served with zero waits
// - other word: new read with wait states
// - always-speculative primary hit copies to secondary, speculates next
// - invalidate lines on init, config, latch, index
// - reset mode is synchronous single buffer
// - single-speculative: miss, then one speculative read
// - always-speculative: copy and launch on every miss, and on primary hits while no speculation runs
// - program whole 128-bit words only
// - pages of 32 flash words
// - small sectors 11-18 first, large follow
// - index select overlays; programmed index unerasable
// - insert programmed read wait states
// - over three waits speculation loses zero-wait
// - flags for burn and erase finished
`timescale 1ns/1ps
module frb_ctrl #(
    parameter int          INIT_CYCLES = 64,
    parameter logic [3:0]  N_LARGE     = 4'hb
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire frb_pkg::frb_ahb_in_s       ahb_in,
    output logic [frb_pkg::BUS_BITS-1:0]    hrdata,
    output logic                            hreadyout,
    output logic                            hresp,
    input  wire logic                       cfg_write,
    input  wire frb_pkg::frb_mode_e         cfg_mode,
    input  wire logic [7:0]                 cfg_wst,
    input  wire logic                       cfg_index_sel,
    input  wire logic                       latch_read,
    input  wire logic                       burn_start,
    input  wire logic [frb_pkg::PAGE_W-1:0] burn_page,
    input  wire logic                       erase_start,
    input  wire logic [4:0]                 erase_sector,
    input  wire logic                       burn_done_clr,
    input  wire logic                       erase_done_clr,
    output frb_pkg::frb_arr_cmd_s           arr_cmd,
    input  wire logic [frb_pkg::FW_BITS-1:0] arr_rdata,
    input  wire logic                       arr_done,
    output logic                            burn_done_flag,
    output logic                            erase_done_flag,
    output logic                            erase_refused,
    output logic                            op_busy,
    output logic                            init_done,
    output logic                            jtag_access_en,
    output logic                            debug_en,
    output logic                            spec_slow,
    output frb_pkg::frb_mode_e              read_mode,
    output logic [7:0]                      read_wait_states,
    output logic                            index_sector_select
);
    localparam int FA = frb_pkg::FW_ADDR_W;
    localparam logic [15:0] INIT_LOAD = 16'(INIT_CYCLES - 1);

    frb_pkg::frb_state_e     state;
    logic [frb_pkg::FW_BITS-1:0] prim, sec, latch, prot;
    logic [FA-1:0]           prim_tag, sec_tag, spec_tag, req_fw, wr_fw;
    logic                    prim_v, sec_v, spec_busy, spec_budget;
    logic [1:0]              req_sel, wr_sel;
    logic                    req_idx, init_go, wr_ph, prot_v;
    logic                    pend_v, pend_wr, op_burn;
    logic                    t_load, t_busy, t_done;
    logic [15:0]             t_value;

    // request decode
    logic               accept, rd_acc, buf_en, dual, async_t;
    logic [frb_pkg::OFS_W-1:0] off;
    logic [FA-1:0]      fw;
    logic [4:0]         sector;
    logic               range_err, sec_err, bad, hit_p, hit_s, erase_blocked;
    logic               ev_err, ev_hit_p, ev_hit_s, ev_miss, join_spec;
    logic               miss_start, init_kick, init_end, fetch_end;
    logic               spec_end, launch, start_pend, invalidate;

    assign accept  = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;
    assign off     = ahb_in.haddr[frb_pkg::OFS_W-1:0];
    assign fw      = off[frb_pkg::OFS_W-1:4];
    assign async_t = read_mode >= frb_pkg::MODE_ASYNC_NOBUF;
    assign buf_en  = read_mode != frb_pkg::MODE_SYNC_NOBUF &&
                     read_mode != frb_pkg::MODE_ASYNC_NOBUF;
    assign dual    = read_mode == frb_pkg::MODE_ASYNC_DUAL1 ||
                     read_mode == frb_pkg::MODE_ASYNC_DUALA;

    // sector number from the flash offset
    always_comb begin
        range_err = 1'b0;
        if (off < frb_pkg::LARGE_OFS) begin
            sector = frb_pkg::SMALL_FIRST + {2'h0, off[15:13]};
        end else begin
            sector = {1'b0, off[19:16] - frb_pkg::LARGE_SKEW};
            range_err = (off[19:16] - frb_pkg::LARGE_SKEW) >= N_LARGE;
        end
    end

    // secured sectors refuse reads once protection is known
    assign sec_err = prot_v && prot[sector] && !index_sector_select;
    assign bad     = range_err || sec_err;
    assign hit_p   = buf_en && prim_v && prim_tag == fw && !index_sector_select;
    assign hit_s   = dual && sec_v && sec_tag == fw && !index_sector_select;

    assign rd_acc    = state == frb_pkg::ST_IDLE && accept && !ahb_in.hwrite;
    assign ev_err    = rd_acc && bad;
    assign ev_hit_p  = rd_acc && !bad && hit_p;
    assign ev_hit_s  = rd_acc && !bad && !hit_p && hit_s;
    assign ev_miss   = rd_acc && !bad && !hit_p && !hit_s;
    assign join_spec = ev_miss && spec_busy && !t_done && fw == spec_tag &&
                       !index_sector_select;
    assign miss_start = ev_miss && !join_spec;
    assign init_kick = state == frb_pkg::ST_INIT && !init_go;
    assign init_end  = state == frb_pkg::ST_INIT && init_go && t_done;
    assign start_pend = init_end && pend_v && !pend_wr;
    assign fetch_end = state == frb_pkg::ST_FETCH && t_done;
    assign spec_end  = state == frb_pkg::ST_IDLE && spec_busy && t_done;
    // speculate after a dual-mode miss, and on primary hits
    // in always-speculative mode
    assign launch = dual && !index_sector_select &&
                    ((fetch_end && (spec_budget ||
                      read_mode == frb_pkg::MODE_ASYNC_DUALA)) ||
                     (ev_hit_p && !spec_busy &&
                      read_mode == frb_pkg::MODE_ASYNC_DUALA));
    assign invalidate = cfg_write || latch_read;

    assign t_load  = init_kick || start_pend || miss_start || launch;
    assign t_value = init_kick ? INIT_LOAD : {8'h00, read_wait_states};

    frb_wait_timer #(
        .W (16)
    ) u_timer (
        .clock (clock),
        .rst_n (rst_n),
        .load  (t_load),
        .value (t_value),
        .busy  (t_busy),
        .done  (t_done)
    );

    // config registers, reset to sync single buffer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            read_mode           <= frb_pkg::MODE_SYNC_SINGLE;
            read_wait_states    <= frb_pkg::WST_RESET;
            index_sector_select <= 1'b0;
        end else if (cfg_write) begin
            read_mode           <= cfg_mode;
            read_wait_states    <= cfg_wst;
            index_sector_select <= cfg_index_sel;
        end
    end

    // main sequence
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state   <= frb_pkg::ST_INIT;
            init_go <= 1'b0;
        end else begin
            case (state)
                frb_pkg::ST_INIT: begin
                    init_go <= 1'b1;
                    if (init_end) begin
                        state <= start_pend ? frb_pkg::ST_FETCH
                                            : frb_pkg::ST_IDLE;
                    end
                end
                frb_pkg::ST_IDLE: begin
                    if (ev_err) begin
                        state <= frb_pkg::ST_ERR1;
                    end else if (ev_miss) begin
                        state <= frb_pkg::ST_FETCH;
                    end
                end
                frb_pkg::ST_FETCH: begin
                    if (t_done) begin
                        state <= frb_pkg::ST_IDLE;
                    end
                end
                frb_pkg::ST_ERR1: state <= frb_pkg::ST_ERR2;
                default:          state <= frb_pkg::ST_IDLE;
            endcase
        end
    end

    // stall in init, fetch and first error cycle
    assign hreadyout = state == frb_pkg::ST_IDLE ||
                       state == frb_pkg::ST_ERR2;
    assign hresp     = state == frb_pkg::ST_ERR1 ||
                       state == frb_pkg::ST_ERR2;

    // request capture, incl. one held over init
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            req_fw  <= '0;
            req_sel <= 2'h0;
            req_idx <= 1'b0;
            pend_v  <= 1'b0;
            pend_wr <= 1'b0;
        end else begin
            if (accept && (state == frb_pkg::ST_IDLE ||
                           state == frb_pkg::ST_INIT)) begin
                req_fw  <= fw;
                req_sel <= ahb_in.haddr[3:2];
                req_idx <= index_sector_select;
            end
            if (accept && state == frb_pkg::ST_INIT) begin
                pend_v  <= 1'b1;
                pend_wr <= ahb_in.hwrite;
            end else if (init_end) begin
                pend_v  <= 1'b0;
            end
        end
    end

    // flash output is primary, secondary a copy
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prim        <= '0;
            sec         <= '0;
            prim_tag    <= '0;
            sec_tag     <= '0;
            spec_tag    <= '0;
            prim_v      <= 1'b0;
            sec_v       <= 1'b0;
            spec_busy   <= 1'b0;
            spec_budget <= 1'b0;
        end else if (init_end || invalidate) begin
            prim_v    <= 1'b0;
            sec_v     <= 1'b0;
            spec_busy <= 1'b0;
        end else begin
            if (miss_start || start_pend) begin
                prim_v      <= 1'b0;
                spec_busy   <= 1'b0;
                spec_budget <= 1'b1;
            end else if (spec_end) begin
                // speculative word lands in the primary line
                prim      <= arr_rdata;
                prim_tag  <= spec_tag;
                prim_v    <= 1'b1;
                spec_busy <= 1'b0;
            end
            if (join_spec) begin
                spec_busy <= 1'b0;
            end
            if (fetch_end) begin
                prim     <= arr_rdata;
                prim_tag <= req_fw;
                prim_v   <= buf_en && !req_idx;
            end
            if (launch) begin
                // copy the latest word aside, then read the next one
                sec         <= fetch_end ? arr_rdata : prim;
                sec_tag     <= fetch_end ? req_fw : prim_tag;
                sec_v       <= 1'b1;
                prim_v      <= 1'b0;
                spec_tag    <= (fetch_end ? req_fw : prim_tag) + 1'b1;
                spec_busy   <= 1'b1;
                spec_budget <= 1'b0;
            end
        end
    end

    // read data: any of the four words of a line
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hrdata <= '0;
        end else if (ev_hit_p) begin
            hrdata <= prim[{ahb_in.haddr[3:2], 5'h00} +: 32];
        end else if (ev_hit_s) begin
            hrdata <= sec[{ahb_in.haddr[3:2], 5'h00} +: 32];
        end else if (fetch_end) begin
            hrdata <= arr_rdata[{req_sel, 5'h00} +: 32];
        end
    end

    // protection word from the power-on index read
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            prot           <= '0;
            prot_v         <= 1'b0;
            init_done      <= 1'b0;
            jtag_access_en <= 1'b0;
            debug_en       <= 1'b0;
        end else if (init_end) begin
            prot           <= arr_rdata;
            prot_v         <= 1'b1;
            init_done      <= 1'b1;
            jtag_access_en <= !arr_rdata[frb_pkg::IDX_JTAG_BIT];
            debug_en       <= !arr_rdata[frb_pkg::IDX_JTAG_BIT];
        end
    end

    // speculation cannot keep up beyond three wait states
    assign spec_slow = dual &&
                       read_wait_states > frb_pkg::SPEC_FULL_WST;

    // write data phase fills the data latch
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ph  <= 1'b0;
            wr_fw  <= '0;
            wr_sel <= 2'h0;
            latch  <= '0;
        end else begin
            wr_ph <= (accept && ahb_in.hwrite &&
                      state == frb_pkg::ST_IDLE) ||
                     (init_end && pend_v && pend_wr);
            if (accept && state == frb_pkg::ST_IDLE) begin
                wr_fw  <= fw;
                wr_sel <= ahb_in.haddr[3:2];
            end else if (init_end) begin
                wr_fw  <= req_fw;
                wr_sel <= req_sel;
            end
            if (wr_ph) begin
                latch[{wr_sel, 5'h00} +: 32] <= ahb_in.hwdata;
            end
        end
    end

    // array commands, one field per kind
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            arr_cmd <= '0;
        end else begin
            arr_cmd.rd    <= 1'b0;
            arr_cmd.abort <= 1'b0;
            arr_cmd.load  <= 1'b0;
            arr_cmd.burn  <= 1'b0;
            arr_cmd.erase <= 1'b0;
            if (init_kick) begin
                arr_cmd.rd      <= 1'b1;
                arr_cmd.index   <= 1'b1;
                arr_cmd.rd_addr <= frb_pkg::IDX_WORD;
            end else if (miss_start || start_pend) begin
                arr_cmd.rd      <= 1'b1;
                // only asynchronous timing may cut a read short
                arr_cmd.abort   <= spec_busy && async_t;
                arr_cmd.index   <= miss_start ? index_sector_select : req_idx;
                arr_cmd.rd_addr <= miss_start ? fw : req_fw;
            end else if (launch) begin
                arr_cmd.rd      <= 1'b1;
                arr_cmd.index   <= 1'b0;
                arr_cmd.rd_addr <= (fetch_end ? req_fw : prim_tag) + 1'b1;
            end
            if (wr_ph && wr_sel == frb_pkg::LAST_LANE) begin
                // a flash word goes to the page only when complete
                arr_cmd.load    <= 1'b1;
                arr_cmd.wr_addr <= wr_fw;
                arr_cmd.wdata   <= {ahb_in.hwdata, latch[95:0]};
            end else if (burn_start && !op_busy) begin
                arr_cmd.burn    <= 1'b1;
                arr_cmd.wr_addr <= {burn_page,
                                    {frb_pkg::PAGE_WORDS_LOG{1'b0}}};
            end
            if (erase_start && !op_busy && !erase_blocked) begin
                arr_cmd.erase  <= 1'b1;
                arr_cmd.sector <= erase_sector;
            end
        end
    end

    // a programmed index sector cannot be erased
    assign erase_blocked = index_sector_select &&
                           prot[frb_pkg::IDX_PROG_BIT];

    // a started burn or erase runs to its end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            op_busy       <= 1'b0;
            op_burn       <= 1'b0;
            erase_refused <= 1'b0;
        end else begin
            erase_refused <= erase_start && !op_busy && erase_blocked;
            if (op_busy) begin
                if (arr_done) begin
                    op_busy <= 1'b0;
                end
            end else if (burn_start) begin
                op_busy <= 1'b1;
                op_burn <= 1'b1;
            end else if (erase_start && !erase_blocked) begin
                op_busy <= 1'b1;
                op_burn <= 1'b0;
            end
        end
    end

    // done flags; set wins over clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            burn_done_flag  <= 1'b0;
            erase_done_flag <= 1'b0;
        end else begin
            if (op_busy && arr_done && op_burn) begin
                burn_done_flag <= 1'b1;
            end else if (burn_done_clr) begin
                burn_done_flag <= 1'b0;
            end
            if (op_busy && arr_done && !op_burn) begin
                erase_done_flag <= 1'b1;
            end else if (erase_done_clr) begin
                erase_done_flag <= 1'b0;
            end
        end
    end
endmodule // frb_ctrl

// [dv/frb_ctrl_asserts.sv]
/* port checker for frb_ctrl; assumes a bind from the bench top file */
`timescale 1ns/1ps
module frb_ctrl_asserts (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  hreadyout,
    input wire frb_pkg::frb_arr_cmd_s arr_cmd,
    input wire logic                  arr_done,
    input wire logic                  burn_start,
    input wire logic                  op_busy,
    input wire logic                  burn_done_flag,
    input wire logic                  erase_done_flag,
    input wire logic                  jtag_access_en,
    input wire logic                  debug_en,
    input wire logic                  spec_slow,
    input wire frb_pkg::frb_mode_e    read_mode,
    input wire logic [7:0]            read_wait_states
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // sync miss, three waits: four stalls
    sequence s_stall4; !hreadyout [*4] ##1 hreadyout; endsequence
    sequence s_init_hold; !hreadyout [*6]; endsequence
    property p_miss;
        arr_cmd.rd && !arr_cmd.index && read_wait_states == 8'h03
        && read_mode == frb_pkg::MODE_SYNC_SINGLE |-> s_stall4;
    endproperty
    property p_init; $rose(rst_n) |-> s_init_hold; endproperty
    property p_index; $rose(rst_n) |=> arr_cmd.rd && arr_cmd.index; endproperty
    property p_sync;
        read_mode <= frb_pkg::MODE_SYNC_SINGLE
        && $past(read_mode) <= frb_pkg::MODE_SYNC_SINGLE |-> !arr_cmd.abort;
    endproperty
    property p_burn; burn_start && !op_busy |=> arr_cmd.burn && op_busy;
    endproperty
    property p_flag;
        $rose(burn_done_flag) || $rose(erase_done_flag) |-> $past(arr_done);
    endproperty
    property p_slow; spec_slow == (read_mode >= frb_pkg::MODE_ASYNC_DUAL1
        && read_wait_states > frb_pkg::SPEC_FULL_WST);
    endproperty
    property p_jtag; debug_en == jtag_access_en; endproperty
    a_miss: assert property (p_miss) else $error("miss stall wrong");
    a_init: assert property (p_init) else $error("ready during init");
    a_index: assert property (p_index) else $error("no index read");
    a_sync: assert property (p_sync) else $error("sync abort");
    a_burn: assert property (p_burn) else $error("burn not issued");
    a_flag: assert property (p_flag) else $error("flag w/o done");
    a_slow: assert property (p_slow) else $error("spec_slow wrong");
    a_jtag: assert property (p_jtag) else $error("debug vs jtag");
endmodule // frb_ctrl_asserts

// [dv/frb_array_model.sv]
/* flash array stand-in; assumes commands from frb_ctrl */
`timescale 1ns/1ps
module frb_array_model (
    input  wire logic                  clock,
    input  wire frb_pkg::frb_arr_cmd_s arr_cmd,
    output logic [127:0]               arr_rdata,
    output logic                       arr_done
);
    logic [3:0] left = 4'h0;
    // each lane tags word and lane; index word clear
    always_comb begin
        for (int k = 0; k < 4; k++)
            arr_rdata[32*k +: 32] = {arr_cmd.rd_addr, 8'h5a, 6'h00, k[1:0]};
        if (arr_cmd.index)
            arr_rdata = '0;
    end
    // burn or erase counts down from six; a new one restarts the count
    always_ff @(posedge clock) begin
        if (arr_cmd.burn || arr_cmd.erase)
            left <= 4'h6;
        else if (left != 4'h0)
            left <= left - 4'h1;
    end
    assign arr_done = (left == 4'h1);
endmodule // frb_array_model

// [dv/flash_read_buffer_ctrl_bench.sv]
/* bench for frb_ctrl; assumes frb_array_model on the array side */
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
    fail_count++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module flash_read_buffer_ctrl_bench;
    logic clock = 0, rst_n = 0, cfg_write = 0, latch_read = 0;
    logic burn_start = 0, erase_start = 0, burn_done_clr = 0;
    logic erase_done_clr = 0, hreadyout, hresp, burn_done_flag;
    logic erase_done_flag, op_busy, init_done, jtag_access_en, debug_en;
    logic spec_slow, arr_done;
    logic [7:0] cfg_wst = 8'h03, read_wait_states;
    logic [31:0] hrdata;
    logic [127:0] arr_rdata;
    frb_pkg::frb_mode_e cfg_mode = frb_pkg::MODE_SYNC_SINGLE, read_mode;
    frb_pkg::frb_ahb_in_s ahb_in = '{1'b1, 32'h0, 2'h0, 1'b0, 32'h0, 1'b1};
    frb_pkg::frb_arr_cmd_s arr_cmd;
    int w, cyc = 0, fail_count = 0, tests_run = 0;
    frb_ctrl #(.INIT_CYCLES(8), .N_LARGE(4'h3)) frb_ctrl_i (.clock, .rst_n,
        .ahb_in, .hrdata, .hreadyout, .hresp, .cfg_write, .cfg_mode, .cfg_wst,
        .cfg_index_sel(1'b0), .latch_read, .burn_start, .burn_page(11'h004),
        .erase_start, .erase_sector(5'h0b), .burn_done_clr, .erase_done_clr,
        .arr_cmd, .arr_rdata, .arr_done, .burn_done_flag, .erase_done_flag,
        .erase_refused(), .op_busy, .init_done, .jtag_access_en, .debug_en,
        .spec_slow, .read_mode, .read_wait_states, .index_sector_select());
    frb_array_model frb_array_model_i (.clock, .arr_cmd, .arr_rdata,
        .arr_done);
    always #4 clock = ~clock;
    // one read; w counts stalled cycles
    task automatic rd(input logic [31:0] a);
        @(posedge clock);
        ahb_in.haddr <= a;
        ahb_in.htrans <= 2'h2;
        @(posedge clock);
        ahb_in.htrans <= 2'h0;
        w = 0;
        @(negedge clock);
        while (hreadyout !== 1'b1 && w < 100) begin
            w++;
            @(negedge clock);
        end
    endtask
    function automatic logic [31:0] ex(input logic [31:0] a);
        return {a[19:4], 8'h5a, 6'h00, a[3:2]};
    endfunction
    task automatic cfg(input frb_pkg::frb_mode_e m, input logic [7:0] ws);
        @(posedge clock);
        cfg_mode <= m;
        cfg_wst <= ws;
        cfg_write <= 1'b1;
        @(posedge clock);
        cfg_write <= 1'b0;
    endtask
    // init stall, hits, misses
    task automatic t_reads();
        rd(32'h2000_0010);
        `CHK("init stall", 1'b1, w > 4)
        `CHK("jtag open", 1'b1, jtag_access_en)
        `CHK("mode", frb_pkg::MODE_SYNC_SINGLE, read_mode)
        for (int k = 1; k < 4; k++) begin
            rd(32'h2000_0010 + 4 * k);
            `CHK("hit wait", 0, w)
            `CHK("hit data", ex(32'h2000_0010 + 4 * k), hrdata)
        end
        rd(32'h2000_0020);
        `CHK("miss wait", 4, w)
        @(posedge clock) latch_read <= 1'b1;
        @(posedge clock) latch_read <= 1'b0;
        rd(32'h2000_0024);
        `CHK("latch inval", 4, w)
        cfg(frb_pkg::MODE_SYNC_NOBUF, 8'h03);
        rd(32'h2000_0028);
        rd(32'h2000_002c);
        `CHK("nobuf wait", 4, w)
        rd(32'h2004_0000);
        `CHK("absent sector", 1'b1, hresp)
        rd(32'h2003_0004);
        `CHK("large data", ex(32'h2003_0004), hrdata)
        cfg(frb_pkg::MODE_ASYNC_DUAL1, 8'h04);
        @(negedge clock) `CHK("spec slow", 1'b1, spec_slow)
        cfg(frb_pkg::MODE_ASYNC_DUALA, 8'h03);
        rd(32'h2000_0040);
        rd(32'h2000_0054);
        `CHK("spec data", ex(32'h2000_0054), hrdata)
    endtask
    // burn, erase, flag clear
    task automatic t_prog();
        @(posedge clock) burn_start <= 1'b1;
        @(posedge clock) burn_start <= 1'b0;
        repeat (12) @(posedge clock);
        erase_start <= 1'b1;
        @(posedge clock) erase_start <= 1'b0;
        repeat (12) @(negedge clock);
        `CHK("burn flag", 2'h3, {burn_done_flag, erase_done_flag})
        @(posedge clock) {burn_done_clr, erase_done_clr} <= 2'h3;
        @(posedge clock) {burn_done_clr, erase_done_clr} <= 2'h0;
        @(negedge clock) `CHK("flag clr", 2'h0, {burn_done_flag, erase_done_flag})
    endtask
    task automatic final_report();
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // cuts a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_reads();
        t_prog();
        final_report();
    end
endmodule // flash_read_buffer_ctrl_bench
bind frb_ctrl frb_ctrl_asserts frb_ctrl_asserts_i (.clock, .rst_n,
    .hreadyout, .arr_cmd, .arr_done, .burn_start, .op_busy, .burn_done_flag,
    .erase_done_flag, .jtag_access_en, .debug_en, .spec_slow, .read_mode,
    .read_wait_states);
